//--- logic/ioodr_regs.vh
// Purpose: shared constants of the output register stage
// Assumes: included by bare name
// Notes:   mode codes for the output path
`ifndef IOODR_REGS_VH
`define IOODR_REGS_VH

`define IOODR_MODE_W        2
`define IOODR_MODE_SDR      2'h0
`define IOODR_MODE_DDR_GEN  2'h1
`define IOODR_MODE_DDR_MEM  2'h2
`define IOODR_RESET_VAL     1'h0

`endif

//--- logic/ioodr_out_mux.v
// Purpose: clock-steered output multiplexer
// Assumes: sel_clk is a clock-like select, used unsampled
// Notes:   high phase shows rise data, low phase fall data
`timescale 1ns/1ps
module ioodr_out_mux #(
  parameter WIDTH = 1
) (
  sel_clk,
  rise_in,
  fall_in,
  mux_out
);
  input  wire             sel_clk;
  input  wire [WIDTH-1:0] rise_in;
  input  wire [WIDTH-1:0] fall_in;
  output wire [WIDTH-1:0] mux_out;

  // two bits per select period
  assign mux_out = sel_clk ? rise_in : fall_in;
endmodule

//--- logic/ioodr_output_reg.v
// Purpose: output register stage of a programmable io cell
// Assumes: core_clk drives both edges; strobe clock is 90 degrees behind
// Notes:   memory mode exists only when MEM_EDGE is set
`timescale 1ns/1ps
`include "ioodr_regs.vh"

module ioodr_output_reg #(
  parameter WIDTH    = 1,
  parameter MEM_EDGE = 1
) (
  core_clk,
  reset,
  out_mode,
  sdr_latch_sel,
  first_data_in,
  second_data_in,
  strobe_shifted_quarter_clock,
  pad_data_out
);
  input  wire                     core_clk;
  input  wire                     reset;
  input  wire [`IOODR_MODE_W-1:0] out_mode;
  input  wire                     sdr_latch_sel;
  input  wire [WIDTH-1:0]         first_data_in;
  input  wire [WIDTH-1:0]         second_data_in;
  input  wire                     strobe_shifted_quarter_clock;
  output reg  [WIDTH-1:0]         pad_data_out;

  reg  [WIDTH-1:0] rise_stage_reg_q;
  reg  [WIDTH-1:0] second_capt_q;
  reg  [WIDTH-1:0] fall_stage_reg_q;
  reg  [WIDTH-1:0] sdr_latch;
  reg  [WIDTH-1:0] sdr_hold_q;
  wire [WIDTH-1:0] ddr_out;
  wire             mem_mode;
  wire             mux_sel;

  assign mem_mode = (MEM_EDGE != 0) && (out_mode == `IOODR_MODE_DDR_MEM);

  // rising edge capture of both inputs
  always @(posedge core_clk) begin
    if (reset) begin
      rise_stage_reg_q <= {WIDTH{`IOODR_RESET_VAL}};
      second_capt_q    <= {WIDTH{`IOODR_RESET_VAL}};
    end else begin
      rise_stage_reg_q <= first_data_in;
      second_capt_q    <= second_data_in;
    end
  end

  // falling edge retime of the second input and hold of the first
  always @(negedge core_clk) begin
    if (reset) begin
      fall_stage_reg_q <= {WIDTH{`IOODR_RESET_VAL}};
      sdr_hold_q       <= {WIDTH{`IOODR_RESET_VAL}};
    end else begin
      fall_stage_reg_q <= second_capt_q;
      sdr_hold_q       <= first_data_in;
    end
  end

  // level latch, transparent while core_clk is high, holds the falling edge value
  always @* begin
    if (reset) begin
      sdr_latch = {WIDTH{`IOODR_RESET_VAL}};
    end else if (core_clk) begin
      sdr_latch = first_data_in;
    end else begin
      sdr_latch = sdr_hold_q;
    end
  end

  assign mux_sel = mem_mode ? strobe_shifted_quarter_clock : core_clk;

  ioodr_out_mux #(
    .WIDTH (WIDTH)
  ) u_mux (
    .sel_clk (mux_sel),
    .rise_in (rise_stage_reg_q),
    .fall_in (fall_stage_reg_q),
    .mux_out (ddr_out)
  );

  // pad source by mode
  always @* begin
    case (out_mode)
      `IOODR_MODE_SDR: begin
        pad_data_out = sdr_latch_sel ? sdr_latch : rise_stage_reg_q;
      end
      `IOODR_MODE_DDR_GEN: begin
        pad_data_out = ddr_out;
      end
      `IOODR_MODE_DDR_MEM: begin
        pad_data_out = ddr_out;
      end
      default: begin
        pad_data_out = rise_stage_reg_q;
      end
    endcase
  end
endmodule

//--- verif/ioodr_chk_asserts.sv
// Purpose: pad timing checks. Assumes: strobe lags core_clk a quarter. Notes: mode 3 is a flop
`timescale 1ns/1ps
module ioodr_chk #(parameter WIDTH=1) (input wire core_clk,reset,sdr_latch_sel,
  strobe_shifted_quarter_clock,input wire [1:0] out_mode,
  input wire [WIDTH-1:0] first_data_in,second_data_in,pad_data_out);
  logic [WIDTH-1:0] f_q,s_q,h_q;
  logic r_q;
  wire c=core_clk,t=strobe_shifted_quarter_clock,g=out_mode==2'h1,m=out_mode==2'h2;
  wire l=!out_mode&&sdr_latch_sel,f=!g&&!m&&!l;
  wire [WIDTH-1:0] p=pad_data_out;
  always @(posedge c) begin
    r_q<=reset; f_q<=reset?'0:first_data_in; s_q<=reset?'0:second_data_in;
  end
  always @(negedge c) h_q<=reset?'0:s_q;
  default disable iff (reset||r_q);
  sequence pair_s; p==f_q ##1 p==h_q; endsequence
  sdr_high_a: assert property(@(negedge c) f|->p==f_q) else $error("pad");
  sdr_low_a: assert property(@(posedge c) f|->p==f_q) else $error("pad");
  sdr_latch_a: assert property(@(negedge c) l|->p==first_data_in) else $error("pad");
  gen_rise_a: assert property(@(negedge c) g|->p==f_q) else $error("pad");
  gen_fall_a: assert property(@(posedge c) g|->p==h_q) else $error("pad");
  gen_pair_a: assert property(@(c) g&&c|->pair_s) else $error("pad");
  mem_rise_a: assert property(@(negedge t) m|->p==f_q) else $error("pad");
  mem_fall_a: assert property(@(posedge t) m|->p==h_q) else $error("pad");
endmodule
bind ioodr_output_reg ioodr_chk #(.WIDTH(WIDTH)) i_chk(.*);

//--- verif/ioodr_strobe.sv
// Purpose: far side strobe source. Assumes: 40 ns clock. Notes: lags by 10 ns
`timescale 1ns/1ps
module ioodr_strobe (input wire core_clk, output logic strobe_shifted_quarter_clock=1'b0);
  always @(core_clk) strobe_shifted_quarter_clock<=#10 core_clk;
endmodule

//--- verif/ioodr_output_reg_test.sv
// Purpose: bench of the output stage. Assumes: WIDTH 1. Notes: step 4 is the latch
`timescale 1ns/1ps
module ioodr_output_reg_test;
  logic core_clk=0,reset=1,sdr_latch_sel=0,first_data_in=0,second_data_in=0,pad_data_out,s;
  logic strobe_shifted_quarter_clock;
  logic [1:0] out_mode=0,c=0,d,n,q[$];
  int fails=0,checks=0,k=0,m;
  ioodr_strobe i_src(.*);
  ioodr_output_reg i_dut(.*);
  initial forever #20 core_clk=~core_clk;
  task chk(input logic v,e);
    checks++;
    if(v!==e) begin fails++; $display("Error pad exp %b seen %b",e,v); end
  endtask
  task close_out;
    $display("checks %0d fails %0d",checks,fails);
    if(!fails&&checks) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge core_clk) if(++k>200) begin fails++; close_out; end
  always @(posedge core_clk) #5 if(q.size()) begin
    n=q.pop_front(); chk(pad_data_out,n[1]);
    #20 chk(pad_data_out,n[0]);
  end
  initial begin
    void'($urandom(1));
    for(m=0;m<5;m++) begin
      @(posedge core_clk) reset<=1; out_mode<=2'(m%4); sdr_latch_sel<=m==4; s=0;
      repeat(3) @(posedge core_clk);
      reset<=0;
      repeat(20) begin
        @(posedge core_clk) d=2'($urandom);
        q.push_back(m==1?c:m==2?{s,c[1]}:m==4?{2{d[1]}}:{2{c[1]}});
        s=c[0]; c=d; {first_data_in,second_data_in}<=d;
      end
    end
    repeat(2) @(posedge core_clk);
    close_out;
  end
endmodule
